// *** clid_decoder.sv ***
// Instruction decoder, address counter and RAMs of the character display controller
`timescale 1ns/1ps
`default_nettype none
module clid_decoder
    import clid_pkg::*;
#(
    parameter int EXEC_CYCLES = EXEC_CYC,
    parameter int EXEC_DATA_CYCLES = EXEC_DATA_CYC,
    parameter int BLINK_CYCLES = BLINK_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic register_select,
    input wire logic read_not_write,
    input wire logic enable,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [6:0] scan_addr,
    output logic [7:0] scan_char,
    output logic display_on,
    output logic cursor_on,
    output logic blink_phase,
    output logic [6:0] cursor_addr,
    output logic [6:0] display_offset,
    output logic bus_width_bit,
    output logic two_line,
    output logic font_tall,
    output logic busy_flag
);
    logic [2:0] rs_s;
    logic [2:0] rw_s;
    logic [2:0] en_s;
    logic [7:0] d1_r;
    logic [7:0] d2_r;
    logic en_prev_r;
    logic rs_q;
    logic rw_q;
    logic en_q;
    logic en_fall;
    logic en_rise;
    logic [7:0] dd_ram [DD_DEPTH];
    logic [7:0] char_generator_ram [CG_DEPTH];
    logic [6:0] address_counter;
    logic sel_cg_r;
    logic inc_r;
    logic entry_shift_bit;
    logic blink_on_r;
    logic nib_phase_r;
    logic [3:0] hi_nib_r;
    logic [7:0] out_reg_r;
    logic [7:0] rd_latch_r;
    logic [31:0] busy_cnt_r;
    logic [31:0] blink_cnt_r;
    logic blink_r;
    clid_state_t state_r;
    logic [7:0] byte_v;
    logic byte_strobe;

    // Step the counter within the legal display ranges
    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up, input logic cg,
            input logic two);
        logic [6:0] n;
        n = up ? a + 7'h01 : a - 7'h01;
        if (cg) begin
            n = n & {1'b0, CG_MASK};
        end else if (!two) begin
            if (up && a == ONE_LAST) n = 7'h00;
            if (!up && a == 7'h00) n = ONE_LAST;
        end else begin
            if (up && a == LINE1_LAST) n = LINE2_FIRST;
            if (up && a == LINE2_LAST) n = 7'h00;
            if (!up && a == LINE2_FIRST) n = LINE1_LAST;
            if (!up && a == 7'h00) n = LINE2_LAST;
        end
        return n;
    endfunction : step_addr

    // Pins are asynchronous to core_clk; two flops before any use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_s <= 3'h0;
        end else begin
            rs_s <= {rs_s[1:0], register_select};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rw_s <= 3'h0;
        end else begin
            rw_s <= {rw_s[1:0], read_not_write};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_s <= 3'h0;
        end else begin
            en_s <= {en_s[1:0], enable};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            d1_r <= 8'h00;
            d2_r <= 8'h00;
        end else begin
            d1_r <= data_in;
            d2_r <= d1_r;
        end
    end

    assign rs_q = rs_s[1];
    assign rw_q = rw_s[1];
    assign en_q = en_s[1];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_prev_r <= 1'b0;
        end else begin
            en_prev_r <= en_q;
        end
    end

    assign en_fall = en_prev_r && !en_q;
    assign en_rise = !en_prev_r && en_q;

    // Nibble phase: high nibble first, the low nibble closes the byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nib_phase_r <= 1'b0;
        end else if (bus_width_bit) begin
            nib_phase_r <= 1'b0;
        end else if (en_fall) begin
            nib_phase_r <= !nib_phase_r;
        end
    end

    // High nibble held until its partner arrives
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_nib_r <= 4'h0;
        end else if (en_fall && !bus_width_bit && !nib_phase_r) begin
            hi_nib_r <= d2_r[7:4];
        end
    end

    assign byte_strobe = en_fall && (bus_width_bit || nib_phase_r);
    assign byte_v = bus_width_bit ? d2_r : {hi_nib_r, d2_r[7:4]};

    assign busy_flag = (state_r == CLID_EXEC);

    // Busy timer; a new instruction while busy is ignored, host must poll
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CLID_IDLE;
            busy_cnt_r <= 32'h0;
        end else begin
            case (state_r)
                CLID_IDLE: begin
                    if (byte_strobe && !(rw_q && !rs_q)) begin
                        state_r <= CLID_EXEC;
                        busy_cnt_r <= rs_q ? 32'(EXEC_DATA_CYCLES) : 32'(EXEC_CYCLES);
                    end
                end
                CLID_EXEC: begin
                    if (busy_cnt_r <= 32'h1) state_r <= CLID_IDLE;
                    else busy_cnt_r <= busy_cnt_r - 32'h1;
                end
                default: state_r <= CLID_IDLE;
            endcase
        end
    end

    // Decoded takes; the instruction and data takes below act only when not busy, while read drive, blink and scan run regardless
    logic take_ok;
    logic is_instr;
    logic is_data_wr;
    logic is_data_rd;
    logic op_set_dd;
    logic op_set_cg;
    logic op_fn_set;
    logic op_shift;
    logic op_disp_ctl;
    logic op_entry;
    logic cursor_move;
    logic disp_move;
    logic [6:0] ac_shift_nxt;
    logic [6:0] ac_step_nxt;
    logic [5:0] cg_read_idx;

    // Opcode class: the highest set bit names the instruction
    function automatic logic op_is(input logic [7:0] b, input int lead);
        return (b >> lead) == 8'h01;
    endfunction : op_is

    // Offset step for display shifts, wraps modulo the offset width
    function automatic logic [6:0] offset_step(input logic [6:0] o, input logic up);
        return up ? o + 7'h01 : o - 7'h01;
    endfunction : offset_step

    // Take qualifiers
    assign take_ok = byte_strobe && !busy_flag;
    assign is_instr = take_ok && !rs_q && !rw_q;
    assign is_data_wr = take_ok && rs_q && !rw_q;
    assign is_data_rd = take_ok && rs_q && rw_q;

    // Instruction classes
    assign op_set_dd = is_instr && op_is(byte_v, 7);
    assign op_set_cg = is_instr && op_is(byte_v, 6);
    assign op_fn_set = is_instr && op_is(byte_v, 5);
    assign op_shift = is_instr && op_is(byte_v, 4);
    assign op_disp_ctl = is_instr && op_is(byte_v, 3);
    assign op_entry = is_instr && op_is(byte_v, 2);
    assign cursor_move = op_shift && !byte_v[3];
    assign disp_move = op_shift && byte_v[3];

    // Address counter candidates
    assign ac_shift_nxt = step_addr(address_counter, byte_v[2], sel_cg_r, two_line);
    assign ac_step_nxt = step_addr(address_counter, inc_r, sel_cg_r, two_line);
    assign cg_read_idx = ac_step_nxt[5:0];

    // Display, cursor and blink latches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            display_on <= 1'b0;
            cursor_on <= 1'b0;
            blink_on_r <= 1'b0;
        end else if (op_disp_ctl) begin
            display_on <= byte_v[2];
            cursor_on <= byte_v[1];
            blink_on_r <= byte_v[0];
        end
    end

    // Entry mode latches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            inc_r <= 1'b1;
            entry_shift_bit <= 1'b0;
        end else if (op_entry) begin
            inc_r <= byte_v[1];
            entry_shift_bit <= byte_v[0];
        end
    end

    // Function set latches; width change takes effect after this byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_width_bit <= 1'b1;
            two_line <= 1'b0;
            font_tall <= 1'b0;
        end else if (op_fn_set) begin
            bus_width_bit <= byte_v[4];
            two_line <= byte_v[3];
            font_tall <= byte_v[2];
        end
    end

    // Which RAM later data accesses reach
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_cg_r <= 1'b0;
        end else if (op_set_dd) begin
            sel_cg_r <= 1'b0;
        end else if (op_set_cg) begin
            sel_cg_r <= 1'b1;
        end
    end

    // Address counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            address_counter <= 7'h00;
        end else if (op_set_dd) begin
            address_counter <= byte_v[6:0];
        end else if (op_set_cg) begin
            address_counter <= {1'b0, byte_v[5:0]};
        end else if (cursor_move) begin
            address_counter <= ac_shift_nxt;
        end else if (is_data_wr || is_data_rd) begin
            address_counter <= ac_step_nxt;
        end
    end

    // Display offset; the counter is left alone here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            display_offset <= 7'h00;
        end else if (disp_move) begin
            display_offset <= offset_step(display_offset, byte_v[2]);
        end else if (is_data_wr && !sel_cg_r && entry_shift_bit) begin
            display_offset <= offset_step(display_offset, inc_r);
        end
    end

    // RAM writes
    always_ff @(posedge core_clk) begin
        if (is_data_wr) begin
            if (sel_cg_r) begin
                char_generator_ram[address_counter[5:0]] <= byte_v;
            end else begin
                dd_ram[address_counter] <= byte_v;
            end
        end
    end

    // Output data register: loaded only by address set, cursor shift or a read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_latch_r <= 8'h00;
        end else if (op_set_dd) begin
            rd_latch_r <= dd_ram[byte_v[6:0]];
        end else if (op_set_cg) begin
            rd_latch_r <= char_generator_ram[byte_v[5:0]];
        end else if (cursor_move && !sel_cg_r) begin
            rd_latch_r <= dd_ram[ac_shift_nxt];
        end else if (is_data_rd) begin
            if (sel_cg_r) begin
                rd_latch_r <= char_generator_ram[cg_read_idx];
            end else begin
                rd_latch_r <= dd_ram[ac_step_nxt];
            end
        end
    end

    // Read drive: value captured at enable rise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg_r <= 8'h00;
        end else if (en_rise && rw_q) begin
            out_reg_r <= rs_q ? rd_latch_r : {busy_flag, address_counter};
        end
    end

    assign data_out = (bus_width_bit || !nib_phase_r) ? out_reg_r : {out_reg_r[3:0], 4'h0};
    assign data_oe = en_q && rw_q;

    // Blink timer; free running so the cell flips at a steady rate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt_r <= 32'h0;
        end else if (blink_cnt_r >= 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_r <= 32'h0;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_r <= 1'b0;
        end else if (blink_cnt_r >= 32'(BLINK_CYCLES - 1)) begin
            blink_r <= !blink_r;
        end
    end

    assign blink_phase = blink_on_r && blink_r;
    assign cursor_addr = address_counter;

    // Scan port for the panel driver; blanked when display is off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_char <= BLANK_CODE;
        end else if (!display_on) begin
            scan_char <= BLANK_CODE;
        end else if (blink_phase && scan_addr == address_counter) begin
            scan_char <= ALL_DOTS;
        end else begin
            scan_char <= dd_ram[scan_addr];
        end
    end
endmodule : clid_decoder
`default_nettype wire

// *** clid_pkg.sv ***
// Constants and types for the character display instruction decoder
// Notes on behaviour
// - Cursor bit shows or hides cursor only
// - Blink bit alternates cursor cell with solid
// - Shift instruction touches no RAM data
// - Shift bits select cursor or display direction
// - Two-line cursor wraps first line to second
// - Display shift applies to all lines
// - Display shift leaves address counter unchanged
// - Width bit selects 8-bit or 4-bit transfers
// - Line bit selects one or two lines
// - Font bit selects 5x8 or 5x11
// - Character address set loads six bits
// - Display address set loads seven bits
// - Display addresses confined to valid ranges; here only stepping wraps, address set loads any seven bits
// - Status read returns busy and counter
// - Data write stores into selected RAM
// - Address steps after each write
// - First read without address set invalid
// - Cursor shift preloads display read data
// - Address steps after each read
// - Read after write returns latched data
// - Busy high while operation executes
// - Display bit blanks or shows display
// - Entry direction high increments address
package clid_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int EXEC_US = 39;
    localparam int EXEC_DATA_US = 43;
    localparam int EXEC_CYC = (EXEC_US * (CLK_HZ / 1_000_000));
    localparam int EXEC_DATA_CYC = (EXEC_DATA_US * (CLK_HZ / 1_000_000));
    localparam int BLINK_MS = 400;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam logic [6:0] LINE1_LAST = 7'h27;
    localparam logic [6:0] LINE2_FIRST = 7'h40;
    localparam logic [6:0] LINE2_LAST = 7'h67;
    localparam logic [6:0] ONE_LAST = 7'h4F;
    localparam logic [5:0] CG_MASK = 6'h3F;
    localparam int DD_DEPTH = 128;
    localparam int CG_DEPTH = 64;
    localparam logic [7:0] BUSY_BIT_POS = 8'h07;
    localparam logic [7:0] ALL_DOTS = 8'hFF;
    localparam logic [7:0] BLANK_CODE = 8'h20;
    localparam logic [2:0] SHIFT_CNT_W = 3'h7;
    typedef enum logic [1:0] {CLID_IDLE, CLID_EXEC} clid_state_t;
endpackage : clid_pkg

// *** clid_decoder_props.sv ***
// Port assertions for the display instruction decoder
`timescale 1ns/1ps
`default_nettype none
module clid_decoder_props
    import clid_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic register_select,
    input wire logic read_not_write,
    input wire logic enable,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic [6:0] scan_addr,
    input wire logic [7:0] scan_char,
    input wire logic display_on,
    input wire logic blink_phase,
    input wire logic [6:0] cursor_addr,
    input wire logic [6:0] display_offset,
    input wire logic bus_width_bit,
    input wire logic two_line,
    input wire logic busy_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_busy_on_take: assert property ($fell(enable) && !read_not_write && !busy_flag && bus_width_bit
        |-> ##[1:8] busy_flag) else $error("busy missing");
    a_busy_holds: assert property ($rose(busy_flag) |-> busy_flag[*8]) else $error("busy short");
    a_settings_held: assert property ($changed({display_on, bus_width_bit, two_line, display_offset})
        |-> (##[0:1] busy_flag) or $past(busy_flag)) else $error("setting changed idle");
    a_shift_keeps_ac: assert property ($changed(display_offset) |-> $stable(cursor_addr))
        else $error("shift moved counter");
    a_status_word: assert property (data_oe && $past(data_oe, 2) && bus_width_bit && !register_select
        && $past(busy_flag, 4) == busy_flag && $past(cursor_addr, 4) == cursor_addr
        |-> data_out == {busy_flag, cursor_addr}) else $error("status wrong");
    a_blank_off: assert property ($past(rst_n) && !$past(display_on) |-> scan_char == BLANK_CODE)
        else $error("not blank");
    a_blink_cell: assert property ($past(rst_n)
        && $past(display_on && blink_phase && scan_addr == cursor_addr) |-> scan_char == ALL_DOTS)
        else $error("cell not solid");
    a_line_range: assert property (two_line |-> cursor_addr <= LINE1_LAST
        || (cursor_addr >= LINE2_FIRST && cursor_addr <= LINE2_LAST)) else $error("counter off lines");
    c_busy: cover property ($rose(busy_flag));
    c_shift: cover property ($changed(display_offset));
    c_nibble: cover property (data_oe && !bus_width_bit);
endmodule : clid_decoder_props
bind clid_decoder clid_decoder_props chk (.*);
`default_nettype wire

// *** clid_host.sv ***
// Host processor model on the display bus
`timescale 1ns/1ps
`default_nettype none
module clid_host (
    input wire logic core_clk,
    output logic register_select,
    output logic read_not_write,
    output logic enable,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out
);
    logic four = 1'b0;
    initial begin
        register_select = 1'b0;
        read_not_write = 1'b1;
        enable = 1'b0;
        data_in = 8'h00;
    end
    task automatic xfer(input logic [1:0] k, input logic [7:0] d, output logic [7:0] q);
        for (int i = 0; i <= int'(four); i++) begin // High nibble first in narrow mode
            @(posedge core_clk);
            {register_select, read_not_write} <= k;
            data_in <= k[0] ? ~data_in : (i == 0 ? d : {d[3:0], 4'h0});
            enable <= 1'b1;
            repeat (5) @(posedge core_clk);
            q = four ? {q[3:0], data_out[7:4]} : data_out;
            enable <= 1'b0;
            repeat (5) @(posedge core_clk);
            data_in <= ~data_in; // Released lines must not look driven
        end
    endtask : xfer
    task automatic cmd(input logic [1:0] k, input logic [7:0] d, output logic [7:0] q, output logic b);
        logic [7:0] s;
        xfer(k, d, q);
        xfer(2'h1, 8'h00, s);
        b = s[7];
        for (int n = 0; s[7] && n < 20; n++) begin // Poll before the next instruction
            xfer(2'h1, 8'h00, s);
        end
    endtask : cmd
endmodule : clid_host
`default_nettype wire

// *** char_lcd_instruction_decoder_test.sv ***
// Self-checking bench for the display instruction decoder
`timescale 1ns/1ps
`default_nettype none
module char_lcd_instruction_decoder_test;
    import clid_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic bp = 1'b1;
    logic [6:0] scan_addr = 7'h00;
    logic register_select, read_not_write, enable, data_oe, blink_phase, busy_flag, display_on, cursor_on;
    logic bus_width_bit, two_line, font_tall;
    logic [7:0] data_in, data_out, scan_char, rd;
    logic [6:0] cursor_addr, display_offset, a, o;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    clid_decoder #(.EXEC_CYCLES(40), .EXEC_DATA_CYCLES(44), .BLINK_CYCLES(8)) uut (.*);
    clid_host host (.*);
    always #12.5 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("mismatches=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic op(input logic [1:0] k, input logic [7:0] d);
        logic b;
        host.cmd(k, d, rd, b);
        chk(8'(b), 8'h01); // Status right after a take
    endtask : op
    task automatic st(input logic [7:0] exp);
        host.xfer(2'h1, 8'h00, rd);
        chk(rd, exp);
    endtask : st
    always @(posedge core_clk) begin
        scan_addr <= cursor_addr;
        cyc <= cyc + 1;
        if (cyc == 20000) begin // Several times the expected run
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({bus_width_bit, display_on, cursor_on, busy_flag, cursor_addr[3:0]}, 8'h80);
        chk(scan_char, BLANK_CODE);
        host.xfer(2'h0, 8'h0F, rd);
        op(2'h0, 8'h08); // Sent while busy, so ignored
        chk({6'h0, display_on, cursor_on}, 8'h03);
        for (int n = 0; n < 40 && !(blink_phase && !bp); n++) begin
            bp = blink_phase;
            @(negedge core_clk);
        end
        repeat (2) @(negedge core_clk);
        chk(scan_char, ALL_DOTS);
        op(2'h0, 8'h85);
        st(8'h05);
        op(2'h2, 8'h41);
        op(2'h2, 8'h42);
        st(8'h07);
        op(2'h0, 8'h85);
        op(2'h3, 8'h00);
        chk(rd, 8'h41); // Address set first, no read to discard
        st(8'h06);
        op(2'h2, 8'h55);
        op(2'h3, 8'h00);
        chk(8'(rd == 8'h55), 8'h00);
        op(2'h0, 8'h85);
        op(2'h0, 8'h14);
        op(2'h3, 8'h00);
        chk(rd, 8'h55);
        st(8'h07);
        for (int i = 0; i < 4; i++) begin
            a = cursor_addr;
            o = display_offset;
            op(2'h0, 8'h10 + 8'(i * 4));
            chk(8'(cursor_addr), 8'(a + 7'(i == 1) - 7'(i == 0)));
            chk(8'(display_offset != o), 8'(i > 1));
        end
        op(2'h0, 8'h04);
        op(2'h2, 8'h33);
        st(8'h06);
        op(2'h0, 8'h06);
        op(2'h2, 8'h34);
        st(8'h07);
        op(2'h0, 8'h43);
        st(8'h03);
        op(2'h2, 8'h1F);
        op(2'h0, 8'h43);
        op(2'h3, 8'h00);
        chk(rd, 8'h1F);
        for (int i = 0; i < 4; i++) begin // Function set sweep over the line and font bits, width kept at eight
            op(2'h0, 8'h30 + 8'(i * 4));
            chk({5'h0, bus_width_bit, two_line, font_tall}, 8'(4 + i));
        end
        op(2'h0, 8'hA7);
        op(2'h0, 8'h14);
        st(8'h40);
        host.xfer(2'h0, 8'h28, rd);
        repeat (60) @(posedge core_clk);
        chk(8'(bus_width_bit), 8'h00);
        host.four = 1'b1;
        st(8'h40);
        op(2'h0, 8'h92);
        st(8'h12);
        conclude();
    end
endmodule : char_lcd_instruction_decoder_test
`default_nettype wire
